// >>> rtl/css_pkg.sv
// Package with types and constants for the card socket status and enable block.
package css_pkg;

  // Battery condition decoded from the two battery-detect lines.
  typedef enum logic [1:0] {
    CSS_BATT_GOOD,
    CSS_BATT_WEAK,
    CSS_BATT_DEAD
  } css_batt_t;

  // Insertion state decoded from the two card-detect lines.
  typedef enum logic [1:0] {
    CSS_CARD_ABSENT,
    CSS_CARD_PARTIAL,
    CSS_CARD_PRESENT
  } css_ins_t;

  // Raw card-side status lines of one socket, all taken synchronous.
  typedef struct packed {
    logic battery_detect_first;
    logic battery_detect_second;
    logic card_detect_first_n;
    logic card_detect_second_n;
  } css_card_in_t;

  // Software-visible status of one socket.
  typedef struct packed {
    logic battery_detect_first;
    logic battery_detect_second;
    logic card_detect_first_n;
    logic card_detect_second_n;
    css_batt_t batt;
    css_ins_t ins;
  } css_status_t;

  // Socket configuration from software.
  typedef struct packed {
    logic io_mode;
    logic dma_mode;
    logic en_batt_dead;
    logic en_batt_warn;
    logic en_detect;
  } css_cfg_t;

  // Reset values and the socket count.
  localparam logic CSS_LINE_IDLE = 1'b1;
  localparam logic CSS_ENABLE_OFF_N = 1'b1;
  localparam logic CSS_FLAG_CLR = 1'b0;
  localparam int CSS_SOCKETS = 2;

endpackage : css_pkg

// >>> rtl/css_socket.sv
// One socket's line decoding: battery state, insertion state and I/O-mode reuse.
`timescale 1ns/1ps
module css_socket
  import css_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire css_pkg::css_card_in_t i_card, // Card status lines.
  input wire css_pkg::css_cfg_t i_cfg, // Socket configuration.
  output css_pkg::css_status_t o_status, // Registered status view.
  output logic o_change_pulse, // One-cycle enabled status change event.
  output logic o_status_change_alert, // Card status-change alert in I/O mode.
  output logic o_card_speaker_in, // Speaker audio from the card.
  output logic o_dma_request // DMA request from the card.
);
  import css_pkg::*;

  css_status_t status_reg;
  css_status_t status_next;

  // Decode the sampled lines; first-line low means dead whatever the second says.
  always_comb begin
    status_next = status_reg;
    status_next.battery_detect_first = i_card.battery_detect_first;
    status_next.battery_detect_second = i_card.battery_detect_second;
    status_next.card_detect_first_n = i_card.card_detect_first_n;
    status_next.card_detect_second_n = i_card.card_detect_second_n;
    if (!i_card.battery_detect_first) begin
      status_next.batt = CSS_BATT_DEAD;
    end else if (!i_card.battery_detect_second) begin
      status_next.batt = CSS_BATT_WEAK;
    end else begin
      status_next.batt = CSS_BATT_GOOD;
    end
    // Both grounds must be made; one alone means a card still sliding in.
    case ({i_card.card_detect_first_n, i_card.card_detect_second_n})
      2'b00: status_next.ins = CSS_CARD_PRESENT;
      2'b11: status_next.ins = CSS_CARD_ABSENT;
      default: status_next.ins = CSS_CARD_PARTIAL;
    endcase
  end

  // Status register; reset shows an empty socket with idle lines.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= '{CSS_LINE_IDLE, CSS_LINE_IDLE, CSS_LINE_IDLE, CSS_LINE_IDLE,
                      CSS_BATT_GOOD, CSS_CARD_ABSENT};
    end else begin
      status_reg <= status_next;
    end
  end

  assign o_status = status_reg;

  // Memory mode change events are gated by their enables.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_change_pulse <= CSS_FLAG_CLR;
    end else begin
      o_change_pulse <= !i_cfg.io_mode &&
        ((i_cfg.en_batt_dead && status_next.batt != status_reg.batt &&
          (status_next.batt == CSS_BATT_DEAD || status_reg.batt == CSS_BATT_DEAD)) ||
         (i_cfg.en_batt_warn && status_next.batt != status_reg.batt) ||
         (i_cfg.en_detect && status_next.ins != status_reg.ins));
    end
  end

  // I/O mode reuses the battery lines; the alert line is active low on the card.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status_change_alert <= CSS_FLAG_CLR;
      o_card_speaker_in <= CSS_FLAG_CLR;
      o_dma_request <= CSS_FLAG_CLR;
    end else begin
      o_status_change_alert <= i_cfg.io_mode && !i_card.battery_detect_first;
      o_card_speaker_in <= i_cfg.io_mode && !i_cfg.dma_mode &&
                           i_card.battery_detect_second;
      o_dma_request <= i_cfg.io_mode && i_cfg.dma_mode &&
                       !i_card.battery_detect_second;
    end
  end

  a_dead_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_card.battery_detect_first |=> status_reg.batt == CSS_BATT_DEAD)
    else $error("dead battery not decoded");
  a_weak_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    i_card.battery_detect_first && !i_card.battery_detect_second
    |=> status_reg.batt == CSS_BATT_WEAK)
    else $error("weak battery not decoded");
  a_good_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    i_card.battery_detect_first && i_card.battery_detect_second
    |=> status_reg.batt == CSS_BATT_GOOD)
    else $error("good battery not decoded");
  a_present_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    (status_reg.ins == CSS_CARD_PRESENT) ==
    (!status_reg.card_detect_first_n && !status_reg.card_detect_second_n))
    else $error("presence does not match detect lines");
  a_partial_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_card.card_detect_first_n != i_card.card_detect_second_n)
    |=> status_reg.ins == CSS_CARD_PARTIAL)
    else $error("partial insertion not flagged");
  a_speaker_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_cfg.io_mode |=> !o_card_speaker_in)
    else $error("speaker active outside io mode");
  a_dma_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cfg.io_mode && i_cfg.dma_mode && !i_card.battery_detect_second |=> o_dma_request)
    else $error("dma request not forwarded");
  a_alert_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cfg.io_mode && !i_card.battery_detect_first |=> o_status_change_alert)
    else $error("status change alert not forwarded");
  a_change_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_cfg.en_batt_dead && !i_cfg.en_batt_warn && !i_cfg.en_detect |=> !o_change_pulse)
    else $error("change event without enable");

endmodule : css_socket

// >>> rtl/css_top.sv
// Two-socket status and byte-enable block with speaker merge.
// Operation
// - Both battery lines high means good
// - Second low, first high means weak battery
// - First battery line low means dead battery
// - Lines readable; change events need enable bits
// - I/O mode alert forwarded to system
// - Second line is speaker only in I/O
// - Both sockets' audio merge into one output
// - Speaker output is XOR of inputs
// - Second line is DMA request when enabled
// - Both card-detect lines low means inserted
// - Card-detect levels visible as status
// - First enable selects even bytes
// - Second enable selects odd bytes
`timescale 1ns/1ps
module css_top
  import css_pkg::*;
(
  input wire logic i_clk, // System clock, 250 MHz.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire css_pkg::css_card_in_t i_card_a, // Socket A status lines.
  input wire css_pkg::css_card_in_t i_card_b, // Socket B status lines.
  input wire css_pkg::css_cfg_t i_cfg_a, // Socket A configuration.
  input wire css_pkg::css_cfg_t i_cfg_b, // Socket B configuration.
  input wire logic i_access_a, // Socket A access in progress.
  input wire logic i_access_b, // Socket B access in progress.
  input wire logic [1:0] i_byte_sel_a, // Socket A lanes: bit0 even, bit1 odd.
  input wire logic [1:0] i_byte_sel_b, // Socket B lanes: bit0 even, bit1 odd.
  output css_pkg::css_status_t o_status_a, // Socket A status view.
  output css_pkg::css_status_t o_status_b, // Socket B status view.
  output logic o_change_a, // Socket A enabled change pulse.
  output logic o_change_b, // Socket B enabled change pulse.
  output logic o_card_status_change_alert, // Alert from either socket.
  output logic o_dma_request_a, // Socket A DMA request.
  output logic o_dma_request_b, // Socket B DMA request.
  output logic o_host_speaker_out, // Merged speaker output.
  output logic o_even_byte_enable_a_n, // Socket A even byte enable, active low.
  output logic o_odd_byte_enable_a_n, // Socket A odd byte enable, active low.
  output logic o_even_byte_enable_b_n, // Socket B even byte enable, active low.
  output logic o_odd_byte_enable_b_n // Socket B odd byte enable, active low.
);
  import css_pkg::*;

  // Per-socket views; index 0 is socket A and index 1 is socket B.
  wire css_card_in_t [CSS_SOCKETS-1:0] card_arr;
  wire css_cfg_t [CSS_SOCKETS-1:0] cfg_arr;
  wire logic [CSS_SOCKETS-1:0] access_vec;
  wire logic [CSS_SOCKETS-1:0][1:0] byte_sel_arr;
  wire css_status_t [CSS_SOCKETS-1:0] status_arr;
  wire logic [CSS_SOCKETS-1:0] change_vec;
  wire logic [CSS_SOCKETS-1:0] alert_vec;
  wire logic [CSS_SOCKETS-1:0] spk_vec;
  wire logic [CSS_SOCKETS-1:0] dma_vec;
  wire logic [CSS_SOCKETS-1:0] even_n_vec;
  wire logic [CSS_SOCKETS-1:0] odd_n_vec;

  // Gather the lettered ports so that one loop serves both sockets.
  assign card_arr = {i_card_b, i_card_a};
  assign cfg_arr = {i_cfg_b, i_cfg_a};
  assign access_vec = {i_access_b, i_access_a};
  assign byte_sel_arr = {i_byte_sel_b, i_byte_sel_a};

  // Spread the per-socket results back onto the lettered ports.
  assign o_status_a = status_arr[0];
  assign o_status_b = status_arr[1];
  assign o_change_a = change_vec[0];
  assign o_change_b = change_vec[1];
  assign o_dma_request_a = dma_vec[0];
  assign o_dma_request_b = dma_vec[1];
  assign o_even_byte_enable_a_n = even_n_vec[0];
  assign o_odd_byte_enable_a_n = odd_n_vec[0];
  assign o_even_byte_enable_b_n = even_n_vec[1];
  assign o_odd_byte_enable_b_n = odd_n_vec[1];

  // One line decoder and one pair of byte enables per socket.
  for (genvar g = 0; g < CSS_SOCKETS; g++) begin : gen_sock
    logic even_n_reg;
    logic odd_n_reg;

    // Line decoding for this socket.
    css_socket u_css_socket (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_card(card_arr[g]),
      .i_cfg(cfg_arr[g]),
      .o_status(status_arr[g]),
      .o_change_pulse(change_vec[g]),
      .o_status_change_alert(alert_vec[g]),
      .o_card_speaker_in(spk_vec[g]),
      .o_dma_request(dma_vec[g])
    );

    // Lanes open only while an access runs on a fully seated card, so a card
    // still sliding in never sees a strobe; the enables idle high.
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        even_n_reg <= CSS_ENABLE_OFF_N;
        odd_n_reg <= CSS_ENABLE_OFF_N;
      end else begin
        even_n_reg <= !(access_vec[g] && byte_sel_arr[g][0] &&
          status_arr[g].ins == CSS_CARD_PRESENT);
        odd_n_reg <= !(access_vec[g] && byte_sel_arr[g][1] &&
          status_arr[g].ins == CSS_CARD_PRESENT);
      end
    end

    // Each block drives only its own bit of the shared vectors.
    assign even_n_vec[g] = even_n_reg;
    assign odd_n_vec[g] = odd_n_reg;

    a_even_enable: assert property (@(posedge i_clk) disable iff (i_rst)
      access_vec[g] && byte_sel_arr[g][0] && status_arr[g].ins == CSS_CARD_PRESENT
      |=> !even_n_reg)
      else $error("even byte enable missing");
    a_odd_enable: assert property (@(posedge i_clk) disable iff (i_rst)
      access_vec[g] && byte_sel_arr[g][1] && status_arr[g].ins == CSS_CARD_PRESENT
      |=> !odd_n_reg)
      else $error("odd byte enable missing");
    a_lane_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      !access_vec[g] |=> even_n_reg && odd_n_reg)
      else $error("byte enable without access");
    a_lane_absent: assert property (@(posedge i_clk) disable iff (i_rst)
      status_arr[g].ins != CSS_CARD_PRESENT |=> even_n_reg && odd_n_reg)
      else $error("byte enable on a card not fully seated");
  end

  // Merged outputs are registered; XOR lets two binary tones mix without a mixer.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_speaker_out <= CSS_FLAG_CLR;
      o_card_status_change_alert <= CSS_FLAG_CLR;
    end else begin
      o_host_speaker_out <= ^spk_vec;
      o_card_status_change_alert <= |alert_vec;
    end
  end

  a_speaker_xor: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_host_speaker_out == ^$past(spk_vec))
    else $error("speaker output is not the xor of sockets");
  a_alert_merge: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_card_status_change_alert == |$past(alert_vec))
    else $error("status change alert not merged");

endmodule : css_top

// >>> tb/css_card_model.sv
// Behavioural model of one inserted card driving its socket status lines.
`timescale 1ns/1ps
module css_card_model
  import css_pkg::*;
(
  input wire logic i_clk, // System clock.
  output css_pkg::css_card_in_t o_card // Card status lines toward the socket.
);
  // Empty socket: detect lines pulled up, battery lines idle high.
  initial o_card = 4'hf;

  // Battery lines double as alert, speaker and DMA request in I/O mode.
  task automatic set_batt(input logic first, input logic second);
    @(posedge i_clk);
    o_card.battery_detect_first <= first;
    o_card.battery_detect_second <= second;
  endtask : set_batt

  // The card grounds both detect lines; a skewed insertion grounds one.
  task automatic set_detect(input logic [1:0] det_n);
    @(posedge i_clk);
    o_card.card_detect_first_n <= det_n[1];
    o_card.card_detect_second_n <= det_n[0];
  endtask : set_detect
endmodule : css_card_model

// >>> tb/tb_css_top.sv
// Self-checking testbench for the two-socket status and byte-enable block.
`timescale 1ns/1ps
module tb_css_top;
  import css_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  css_card_in_t card_a, card_b;
  css_cfg_t cfg_a = '0, cfg_b = '0;
  logic acc_a = 1'b0, acc_b = 1'b0;
  logic [1:0] sel_a = 2'h0, sel_b = 2'h0;
  css_status_t st_a, st_b;
  logic chg_a, chg_b, alert, dma_a, dma_b, spk, ev_a_n, od_a_n, ev_b_n, od_b_n;
  int mismatches = 0, checks_done = 0, pulses = 0, pulses_b = 0;
  logic [1:0] b [4] = '{2'h3, 2'h2, 2'h1, 2'h0};

  always #2 i_clk = ~i_clk;

  css_card_model u_card_a (.i_clk(i_clk), .o_card(card_a));
  css_card_model u_card_b (.i_clk(i_clk), .o_card(card_b));
  css_top u_css_top (.i_clk(i_clk), .i_rst(i_rst), .i_card_a(card_a), .i_card_b(card_b),
    .i_cfg_a(cfg_a), .i_cfg_b(cfg_b), .i_access_a(acc_a), .i_access_b(acc_b),
    .i_byte_sel_a(sel_a), .i_byte_sel_b(sel_b), .o_status_a(st_a), .o_status_b(st_b),
    .o_change_a(chg_a), .o_change_b(chg_b), .o_card_status_change_alert(alert),
    .o_dma_request_a(dma_a), .o_dma_request_b(dma_b), .o_host_speaker_out(spk),
    .o_even_byte_enable_a_n(ev_a_n), .o_odd_byte_enable_a_n(od_a_n),
    .o_even_byte_enable_b_n(ev_b_n), .o_odd_byte_enable_b_n(od_b_n));

  // Pulses are counted rather than caught, so their exact cycle need not be guessed.
  always @(posedge i_clk) if (chg_a === 1'b1) pulses <= pulses + 1;
  always @(posedge i_clk) if (chg_b === 1'b1) pulses_b <= pulses_b + 1;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  task automatic drive(input css_cfg_t ca, input css_cfg_t cb, input logic aa,
                       input logic [1:0] sa);
    @(posedge i_clk);
    cfg_a <= ca;
    cfg_b <= cb;
    acc_a <= aa;
    sel_a <= sa;
    acc_b <= aa;
    sel_b <= sa;
  endtask : drive

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  initial begin
    repeat (2000) @(posedge i_clk);
    mismatches++;
    results();
  end

  initial begin
    css_batt_t eb;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    settle(1);
    check(st_a, {4'hf, CSS_BATT_GOOD, CSS_CARD_ABSENT});
    check({ev_a_n, od_a_n, alert, spk}, 4'hc);
    $display("test reset done");
    // Detect pairs: both low present, one low partial, none absent.
    for (int i = 0; i < 4; i++) begin
      u_card_a.set_detect(b[i]);
      settle(2);
      check({st_a.card_detect_first_n, st_a.card_detect_second_n}, b[i]);
      check(st_a.ins, i == 3 ? CSS_CARD_PRESENT : i == 0 ? CSS_CARD_ABSENT
                      : CSS_CARD_PARTIAL);
    end
    $display("test detect done");
    // Memory mode, warn enable on: GOOD to WEAK to DEAD to DEAD gives two pulses.
    drive(5'h02, 5'h00, 1'b0, 2'h0);
    for (int i = 1; i < 4; i++) begin
      u_card_a.set_batt(b[i][1], b[i][0]);
      settle(3);
      eb = i == 1 ? CSS_BATT_WEAK : CSS_BATT_DEAD;
      check(st_a.batt, eb);
      check({st_a.battery_detect_first, st_a.battery_detect_second}, b[i]);
    end
    check(pulses, 2);
    // Enables off: return to good raises no pulse.
    drive(5'h00, 5'h00, 1'b0, 2'h0);
    u_card_a.set_batt(1'b1, 1'b1);
    settle(3);
    check(st_a.batt, CSS_BATT_GOOD);
    check(pulses, 2);
    // Dead enable alone: weak raises nothing, entering dead raises one.
    drive(5'h04, 5'h00, 1'b0, 2'h0);
    u_card_a.set_batt(1'b1, 1'b0);
    settle(3);
    check(pulses, 2);
    u_card_a.set_batt(1'b0, 1'b0);
    settle(3);
    check(st_a.batt, CSS_BATT_DEAD);
    check(pulses, 3);
    $display("test battery done");
    // Byte lanes on A (present); B stays empty, so its enables stay off.
    for (int s = 1; s < 4; s++) begin
      drive(5'h00, 5'h00, 1'b1, s[1:0]);
      settle(2);
      check({ev_a_n, od_a_n}, {~s[0], ~s[1]});
      check({ev_b_n, od_b_n}, 2'h3);
    end
    // Seat card B under a running access with its detect event enabled.
    drive(5'h00, 5'h01, 1'b1, 2'h3);
    u_card_b.set_detect(2'h0);
    settle(2);
    check(st_b.ins, CSS_CARD_PRESENT);
    check({ev_b_n, od_b_n}, 2'h0);
    check(pulses_b, 1);
    drive(5'h00, 5'h00, 1'b0, 2'h0);
    settle(2);
    check({ev_a_n, od_a_n}, 2'h3);
    check({ev_b_n, od_b_n}, 2'h3);
    $display("test enables done");
    // I/O mode: alert on first line low; DMA request on B; speaker XOR.
    drive(5'h10, 5'h18, 1'b0, 2'h0);
    u_card_a.set_batt(1'b0, 1'b1);
    u_card_b.set_batt(1'b1, 1'b0);
    settle(3);
    check({alert, dma_a, dma_b, spk}, 4'hb);
    drive(5'h10, 5'h10, 1'b0, 2'h0);
    u_card_b.set_batt(1'b1, 1'b1);
    settle(3);
    check({alert, dma_b, spk}, 3'h4);
    u_card_a.set_batt(1'b1, 1'b1);
    u_card_b.set_batt(1'b1, 1'b0);
    settle(3);
    check({alert, spk}, 2'h1);
    drive(5'h00, 5'h00, 1'b0, 2'h0);
    settle(3);
    check(spk, 1'b0);
    $display("test io mode done");
    results();
  end
endmodule : tb_css_top
